// ### dv/fsp_cpu_model.sv
// Model of the CPU program that runs the rewrite library around the controller.
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic lp_req,
    input  wire logic gie_req,
    input  wire logic irq_req,
    input  wire logic busy,
    input  wire logic lp_settled,
    output logic      low_power_mode,
    output logic      global_interrupt_enable_flag,
    output logic      irq_unmasked,
    output logic      start_ok
);
    // The power mode only moves between steps, so a running step never sees it change.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_power_mode <= 1'b0;
        end else if (!busy) begin
            low_power_mode <= lp_req;
        end
    end
    // The program sets the enable flag and unmasks the source before it wants interrupts.
    assign global_interrupt_enable_flag = gie_req;
    assign irq_unmasked                 = irq_req;
    // A step may start in low power mode only once the settling wait is over.
    assign start_ok = !low_power_mode || lp_settled;
endmodule
`default_nettype wire

// ### dv/fsp_ctrl_bench.sv
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_bench;
    import fsp_pkg::*;
    localparam int unsigned OPC  = 12;
    localparam int unsigned SETC = 20;
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       byte_wr = 1'b0;
    logic [7:0] wdata   = 8'h00;
    logic       bit_wr  = 1'b0;
    logic [2:0] bit_idx = 3'h0;
    logic       bit_val = 1'b0;
    logic       cmd_valid = 1'b0;
    fsp_op_t    cmd_op  = FSP_OP_ERASE;
    logic       cmd_data_area = 1'b0;
    logic [3:0] cmd_block = 4'h0;
    logic [3:0] rd_block  = 4'h0;
    logic       resume_req = 1'b0;
    logic       lp_req  = 1'b0;
    logic       gie_req = 1'b0;
    logic       irq_req = 1'b0;
    logic [7:0] mode;
    logic       lp, lp_settled, gie, irq, start_ok, rd_blocked, busy, suspended;
    logic       cmd_done, cmd_err, irq_take, flash_erase_en, flash_prog_en;
    logic       seen_e, seen_p, got_done, got_err;
    int         miscompares = 0;
    int         n_compared  = 0;
    int         n;

    // Free-running 20 MHz clock.
    always #25 ref_clk = ~ref_clk;

    fsp_ctrl #(.NUM_BLOCKS(16), .OP_CYCLES(OPC), .SETTLE_CYCLES(SETC)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .ctrl_byte_wr(byte_wr), .ctrl_wdata(wdata),
        .ctrl_bit_wr(bit_wr), .ctrl_bit_idx(bit_idx), .ctrl_bit_val(bit_val),
        .self_prog_mode_ctrl(mode), .low_power_mode(lp), .lp_settled(lp_settled),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data_area(cmd_data_area),
        .cmd_block(cmd_block), .resume_req(resume_req),
        .global_interrupt_enable_flag(gie), .irq_unmasked(irq), .rd_block(rd_block),
        .rd_blocked(rd_blocked), .busy(busy), .suspended(suspended), .cmd_done(cmd_done),
        .cmd_err(cmd_err), .irq_take(irq_take), .flash_erase_en(flash_erase_en),
        .flash_prog_en(flash_prog_en));

    fsp_cpu_model u_cpu (
        .ref_clk(ref_clk), .rst(rst), .lp_req(lp_req), .gie_req(gie_req),
        .irq_req(irq_req), .busy(busy), .lp_settled(lp_settled), .low_power_mode(lp),
        .global_interrupt_enable_flag(gie), .irq_unmasked(irq), .start_ok(start_ok));

    // Compares one result and counts it.
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Writes the mode byte, by a single bit or a whole byte, and reads it back.
    task automatic wr_mode(input logic is_byte, input logic [7:0] d, input logic [7:0] exp);
        @(posedge ref_clk);
        byte_wr <= is_byte;
        bit_wr  <= !is_byte;
        wdata   <= d;
        bit_idx <= d[6:4];
        bit_val <= d[0];
        @(posedge ref_clk);
        byte_wr <= 1'b0;
        bit_wr  <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("mode_ctrl", exp, mode);
    endtask

    // Presents one separate erase or write request, never a combined one, once allowed.
    task automatic issue(input fsp_op_t op, input logic dat, input logic [3:0] blk);
        for (int k = 0; k < 200 && start_ok !== 1'b1; k++) begin
            @(posedge ref_clk);
        end
        @(posedge ref_clk);
        cmd_valid     <= 1'b1;
        cmd_op        <= op;
        cmd_data_area <= dat;
        cmd_block     <= blk;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask

    // Waits for done or refusal, noting which array strobes were seen.
    task automatic await();
        n = 0;
        {seen_e, seen_p, got_done, got_err} = 4'h0;
        #1;
        got_err = cmd_err; // A refusal stands only in the cycle after the request edge.
        while (n < 200 && got_done !== 1'b1 && got_err !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            seen_e   = seen_e | flash_erase_en;
            seen_p   = seen_p | flash_prog_en;
            got_done = cmd_done;
            got_err  = cmd_err;
        end
    endtask

    // Runs one whole step and checks refusal, strobes and completion time.
    task automatic step(input fsp_op_t op, input logic dat, input logic [3:0] blk,
                        input logic e_err, input logic e_e, input logic e_p);
        issue(op, dat, blk);
        await();
        chk("cmd_err", {7'h00, e_err}, {7'h00, got_err});
        chk("erase_en", {7'h00, e_e}, {7'h00, seen_e});
        chk("prog_en", {7'h00, e_p}, {7'h00, seen_p});
        chk("latency", e_err ? 8'h00 : 8'(OPC + 1), n[7:0]);
    endtask

    // Cuts a hung run short.
    initial begin
        #(50 * 20000);
        miscompares++;
        end_sim();
    end

    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("mode_ctrl", 8'h00, mode);
        wr_mode(1'b0, 8'h31, 8'h00);
        step(FSP_OP_ERASE, 1'b0, 4'h1, 1'b0, 1'b0, 1'b0);
        wr_mode(1'b0, 8'h01, 8'h01);
        wr_mode(1'b1, 8'hFE, 8'h00);
        wr_mode(1'b1, 8'hFF, 8'h01);
        step(FSP_OP_WRITE, 1'b0, 4'h1, 1'b1, 1'b0, 1'b0);
        step(FSP_OP_ERASE, 1'b0, 4'h2, 1'b0, 1'b1, 1'b0);
        step(FSP_OP_WRITE, 1'b0, 4'h2, 1'b0, 1'b0, 1'b1);
        step(FSP_OP_WRITE, 1'b0, 4'h2, 1'b1, 1'b0, 1'b0);
        issue(FSP_OP_ERASE, 1'b0, 4'h3);
        irq_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("suspended", 8'h00, {7'h00, suspended});
        @(posedge ref_clk);
        gie_req <= 1'b1;
        for (int k = 0; k < 8 && irq_take !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("irq_take", 8'h01, {7'h00, irq_take});
        chk("erase_en", 8'h00, {7'h00, flash_erase_en});
        repeat (3) @(posedge ref_clk);
        #1;
        chk("suspended", 8'h01, {7'h00, suspended});
        @(posedge ref_clk);
        irq_req    <= 1'b0;
        gie_req    <= 1'b0;
        resume_req <= 1'b1;
        @(posedge ref_clk);
        resume_req <= 1'b0;
        await();
        chk("cmd_done", 8'h01, {7'h00, got_done});
        chk("erase_en", 8'h01, {7'h00, seen_e});
        step(FSP_OP_WRITE, 1'b0, 4'h3, 1'b0, 1'b0, 1'b1);
        lp_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        step(FSP_OP_ERASE, 1'b0, 4'h4, 1'b1, 1'b0, 1'b0);
        chk("lp_settled", 8'h01, {7'h00, lp_settled});
        step(FSP_OP_ERASE, 1'b1, 4'h5, 1'b0, 1'b1, 1'b0);
        step(FSP_OP_WRITE, 1'b1, 4'h5, 1'b0, 1'b0, 1'b1);
        rd_block <= 4'h5;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("rd_blocked", 8'h00, {7'h00, rd_blocked});
        lp_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("rd_blocked", 8'h01, {7'h00, rd_blocked});
        issue(FSP_OP_ERASE, 1'b0, 4'h6);
        repeat (3) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("mode_ctrl", 8'h00, mode);
        chk("busy", 8'h00, {7'h00, busy});
        @(posedge ref_clk);
        rst <= 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire

// ### rtl/fsp_ctrl.sv
// Flash self-programming mode register, step sequencer and area guards.
//
// Overview of operation
// RULE1 - Enabled unmasked interrupt suspends rewrite, vectors out.
// RULE2 - Suspended rewrite resumes after self-programming re-entered.
// RULE3 - Interrupt latency during rewrite may differ.
// RULE4 - Software gates interrupts with enable flag, masks.
// RULE5 - Regulator voltage mode stays fixed during rewrite.
// RULE6 - Normal power mode permits program area rewrite.
// RULE7 - Low power mode: data area only, program refused.
// RULE8 - Low power written blocks unreadable in normal mode.
// RULE9 - Blocks must be erased before being programmed.
// RULE10 - Software waits 2 ms after entering low power.
// RULE11 - Reset clears mode control byte to zero.
// RULE12 - Mode byte accepts bit writes and byte writes.
// RULE13 - Programmer avoids combined command during boot swap.
// RULE14 - Serial programming timings are reference figures only.
// RULE15 - Select bit zero: library runs, array untouched.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int unsigned NUM_BLOCKS    = NUM_BLOCKS_DEF,
    parameter int unsigned OP_CYCLES     = OP_CYCLES_DEF,
    parameter int unsigned SETTLE_CYCLES = LP_SETTLE_CYC
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          ctrl_byte_wr,
    input  wire logic [MODE_CTRL_W-1:0]        ctrl_wdata,
    input  wire logic                          ctrl_bit_wr,
    input  wire logic [2:0]                    ctrl_bit_idx,
    input  wire logic                          ctrl_bit_val,
    output logic      [MODE_CTRL_W-1:0]        self_prog_mode_ctrl,
    input  wire logic                          low_power_mode,
    output logic                               lp_settled,
    input  wire logic                          cmd_valid,
    input  wire fsp_op_t                       cmd_op,
    input  wire logic                          cmd_data_area,
    input  wire logic [$clog2(NUM_BLOCKS)-1:0] cmd_block,
    input  wire logic                          resume_req,
    input  wire logic                          global_interrupt_enable_flag,
    input  wire logic                          irq_unmasked,
    input  wire logic [$clog2(NUM_BLOCKS)-1:0] rd_block,
    output logic                               rd_blocked,
    output logic                               busy,
    output logic                               suspended,
    output logic                               cmd_done,
    output logic                               cmd_err,
    output logic                               irq_take,
    output logic                               flash_erase_en,
    output logic                               flash_prog_en
);
    localparam int unsigned BW = $clog2(NUM_BLOCKS);
    localparam int unsigned TW = $clog2(OP_CYCLES + 1);
    localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);

    // Parameters the logic cannot serve are refused at elaboration.
    if (NUM_BLOCKS < 2 || OP_CYCLES < 1 || SETTLE_CYCLES < 1) begin : g_param_check
        $error("fsp_ctrl: NUM_BLOCKS >= 2, OP_CYCLES >= 1, SETTLE_CYCLES >= 1 required");
    end

    logic                  self_prog_select_bit;
    logic                  next_sel;
    fsp_state_t            state;
    fsp_state_t            next_state;
    fsp_op_t               op;
    fsp_op_t               next_op;
    logic [BW-1:0]         blk;
    logic [BW-1:0]         next_blk;
    logic                  op_real;
    logic                  next_op_real;
    logic                  op_lp;
    logic                  next_op_lp;
    logic [NUM_BLOCKS-1:0] erased;
    logic [NUM_BLOCKS-1:0] next_erased;
    logic [NUM_BLOCKS-1:0] lp_data;
    logic [NUM_BLOCKS-1:0] next_lp_data;
    logic [SW-1:0]         settle_cnt;
    logic [SW-1:0]         next_settle_cnt;
    logic                  next_done;
    logic                  next_err;
    logic                  next_irq_take;
    logic                  next_erase_en;
    logic                  next_prog_en;
    logic                  next_rd_blocked;
    logic                  t_load;
    logic                  t_run;
    logic [TW-1:0]         t_count;
    logic                  t_zero;
    logic                  irq_hit;
    logic                  refuse;

    // Byte write replaces the select bit, a bit write touches only its bit.
    always_comb begin
        next_sel = self_prog_select_bit;
        if (ctrl_byte_wr) begin
            next_sel = ctrl_wdata[SEL_BIT_POS]; // RULE12
        end else if (ctrl_bit_wr && ctrl_bit_idx == SEL_BIT_POS) begin
            next_sel = ctrl_bit_val; // RULE12
        end
    end

    // Mode register, cleared by any reset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            self_prog_select_bit <= MODE_CTRL_RESET[SEL_BIT_POS]; // RULE11
        end else begin
            self_prog_select_bit <= next_sel;
        end
    end

    // Upper bits are unimplemented and read as zero.
    assign self_prog_mode_ctrl = {{(MODE_CTRL_W-1){1'b0}}, self_prog_select_bit};

    // Status counter of time spent in low power mode, restarted on leaving it.
    always_comb begin
        next_settle_cnt = settle_cnt;
        if (!low_power_mode) begin
            next_settle_cnt = '0;
        end else if (settle_cnt != SW'(SETTLE_CYCLES)) begin
            next_settle_cnt = settle_cnt + SW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            settle_cnt <= '0;
        end else begin
            settle_cnt <= next_settle_cnt;
        end
    end

    assign lp_settled = (settle_cnt == SW'(SETTLE_CYCLES)); // RULE10

    // An interrupt only breaks in when globally enabled and unmasked.
    assign irq_hit = (state == FSP_RUN) && global_interrupt_enable_flag && irq_unmasked; // RULE1

    // Program area is refused in low power; unerased blocks refuse a real write.
    assign refuse = (low_power_mode && !cmd_data_area) // RULE7
                  || (cmd_op == FSP_OP_WRITE && self_prog_select_bit && !erased[cmd_block]); // RULE9

    // Sequencer: start, count, suspend on interrupt, resume, finish.
    always_comb begin
        next_state      = state;
        next_op         = op;
        next_blk        = blk;
        next_op_real    = op_real;
        next_op_lp      = op_lp;
        next_erased     = erased;
        next_lp_data    = lp_data;
        next_done       = 1'b0;
        next_err        = 1'b0;
        next_irq_take   = 1'b0;
        t_load          = 1'b0;
        t_run           = 1'b0;
        unique case (state)
            FSP_IDLE: begin
                if (cmd_valid && refuse) begin
                    next_err = 1'b1;
                end else if (cmd_valid) begin
                    next_state   = FSP_RUN; // RULE6
                    next_op      = cmd_op;
                    next_blk     = cmd_block;
                    next_op_real = self_prog_select_bit; // RULE15
                    next_op_lp   = low_power_mode;
                    t_load       = 1'b1;
                end
            end
            FSP_RUN: begin
                if (irq_hit) begin
                    // The step parks on the same edge that irq_take is raised to vector out.
                    next_state    = FSP_SUSP; // RULE3
                    next_irq_take = 1'b1; // RULE1
                end else if (t_zero) begin
                    next_state = FSP_IDLE;
                    next_done  = 1'b1;
                    if (op_real) begin
                        next_erased[blk]  = (op == FSP_OP_ERASE); // RULE9
                        next_lp_data[blk] = op_lp; // RULE8
                    end
                end else begin
                    t_run = 1'b1;
                end
            end
            FSP_SUSP: begin
                // The timer holds its remaining count while parked.
                if (resume_req && self_prog_select_bit) begin
                    next_state = FSP_RUN; // RULE2
                end
            end
        endcase
    end

    // Array strobes only when the select bit is set during a live step.
    assign next_erase_en = (state == FSP_RUN) && !irq_hit && !t_zero && op_real
                         && self_prog_select_bit && (op == FSP_OP_ERASE); // RULE15
    assign next_prog_en  = (state == FSP_RUN) && !irq_hit && !t_zero && op_real
                         && self_prog_select_bit && (op == FSP_OP_WRITE); // RULE15
    assign next_rd_blocked = !low_power_mode && lp_data[rd_block]; // RULE8

    // Sequencer registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state          <= FSP_IDLE;
            op             <= FSP_OP_ERASE;
            blk            <= '0;
            op_real        <= 1'b0;
            op_lp          <= 1'b0;
            erased         <= '0;
            lp_data        <= '0;
            cmd_done       <= 1'b0;
            cmd_err        <= 1'b0;
            irq_take       <= 1'b0;
            flash_erase_en <= 1'b0;
            flash_prog_en  <= 1'b0;
            rd_blocked     <= 1'b0;
        end else begin
            state          <= next_state;
            op             <= next_op;
            blk            <= next_blk;
            op_real        <= next_op_real;
            op_lp          <= next_op_lp;
            erased         <= next_erased;
            lp_data        <= next_lp_data;
            cmd_done       <= next_done;
            cmd_err        <= next_err;
            irq_take       <= next_irq_take;
            flash_erase_en <= next_erase_en;
            flash_prog_en  <= next_prog_en;
            rd_blocked     <= next_rd_blocked;
        end
    end

    assign busy      = (state != FSP_IDLE);
    assign suspended = (state == FSP_SUSP);

    // Step duration timer.
    fsp_op_timer #(.W(TW)) u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .load     (t_load),
        .load_val (TW'(OP_CYCLES)), // RULE14
        .run      (t_run),
        .count    (t_count),
        .zero     (t_zero)
    );

    // Checks on the sequencer and the mode register.
    property p_irq_suspend;
        @(posedge ref_clk) disable iff (rst)
        irq_hit |=> irq_take && suspended ##1 !irq_take;
    endproperty
    a_irq_suspend: assert property (p_irq_suspend) else $error("interrupt did not suspend"); // RULE1

    property p_resume;
        @(posedge ref_clk) disable iff (rst)
        suspended && resume_req && self_prog_select_bit |=> busy && !suspended;
    endproperty
    a_resume: assert property (p_resume) else $error("suspended step did not resume"); // RULE2

    property p_susp_hold;
        @(posedge ref_clk) disable iff (rst)
        suspended ##1 suspended |-> t_count == $past(t_count);
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("timer moved while suspended"); // RULE2

    property p_lp_refuse;
        @(posedge ref_clk) disable iff (rst)
        !busy && cmd_valid && low_power_mode && !cmd_data_area |=> cmd_err && !busy;
    endproperty
    a_lp_refuse: assert property (p_lp_refuse) else $error("program area accepted in low power"); // RULE7

    property p_normal_prog;
        @(posedge ref_clk) disable iff (rst)
        !busy && cmd_valid && !low_power_mode && cmd_op == FSP_OP_ERASE |=> busy && !cmd_err;
    endproperty
    a_normal_prog: assert property (p_normal_prog) else $error("normal mode erase refused"); // RULE6

    property p_no_overwrite;
        @(posedge ref_clk) disable iff (rst)
        !busy && cmd_valid && cmd_op == FSP_OP_WRITE && self_prog_select_bit
            && !erased[cmd_block] |=> cmd_err && !busy;
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) else $error("write to unerased block"); // RULE9

    property p_no_array_normal;
        @(posedge ref_clk) disable iff (rst)
        !self_prog_select_bit |=> !flash_erase_en && !flash_prog_en;
    endproperty
    a_no_array_normal: assert property (p_no_array_normal) else $error("array driven in normal mode"); // RULE15

    property p_bit_write;
        @(posedge ref_clk) disable iff (rst)
        ctrl_bit_wr && !ctrl_byte_wr && ctrl_bit_idx == SEL_BIT_POS
            |=> self_prog_mode_ctrl == {7'h00, $past(ctrl_bit_val)};
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write not taken"); // RULE12

    property p_byte_write;
        @(posedge ref_clk) disable iff (rst)
        ctrl_byte_wr |=> self_prog_select_bit == $past(ctrl_wdata[0]);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("byte write not taken"); // RULE12

    property p_lp_read;
        @(posedge ref_clk) disable iff (rst)
        !low_power_mode && lp_data[rd_block] |=> rd_blocked;
    endproperty
    a_lp_read: assert property (p_lp_read) else $error("low power data readable"); // RULE8

    c_suspend: cover property (@(posedge ref_clk) disable iff (rst) irq_take ##[1:20] cmd_done);
    c_erase_write: cover property (@(posedge ref_clk) disable iff (rst)
        flash_erase_en ##[1:100] flash_prog_en);
    c_refuse: cover property (@(posedge ref_clk) disable iff (rst) cmd_err);
endmodule
`default_nettype wire

// ### rtl/fsp_op_timer.sv
// Down counter that measures how long a flash step keeps the array busy.
`timescale 1ns/1ps
`default_nettype none
module fsp_op_timer #(
    parameter int unsigned W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         run,
    output logic      [W-1:0] count,
    output logic              zero
);
    logic [W-1:0] next_count;

    // Load wins, otherwise count down while running and hold when paused.
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (run && count != '0) begin
            next_count = count - W'(1);
        end
    end

    // Register the count.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign zero = (count == '0);
endmodule
`default_nettype wire

// ### rtl/fsp_pkg.sv
// Shared constants and types for the flash self-programming controller.
package fsp_pkg;

    // Clock rate of ref_clk in kHz.
    localparam int unsigned CLK_KHZ         = 20000;
    // Settling wait after entering low power mode, in microseconds.
    localparam int unsigned LP_SETTLE_US    = 2000;
    // Settling wait in clock cycles, rounded up.
    localparam int unsigned LP_SETTLE_CYC   = (LP_SETTLE_US * CLK_KHZ + 999) / 1000;

    // Mode control byte: reset value, width and the select bit position.
    localparam logic [7:0]  MODE_CTRL_RESET = 8'h00;
    localparam int unsigned MODE_CTRL_W     = 8;
    localparam logic [2:0]  SEL_BIT_POS     = 3'h0;

    // Default cycles that one erase or program step occupies the array.
    localparam int unsigned OP_CYCLES_DEF   = 16;
    // Default number of flash blocks tracked.
    localparam int unsigned NUM_BLOCKS_DEF  = 16;

    // Serial programming reference conditions, kept for documentation only.
    localparam int unsigned REF_OSC_KHZ     = 8000;
    localparam int unsigned REF_BAUD        = 500000;

    // Sequencer states.
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_RUN,
        FSP_SUSP
    } fsp_state_t;

    // Flash operations requested by the rewrite library.
    typedef enum logic {
        FSP_OP_ERASE,
        FSP_OP_WRITE
    } fsp_op_t;

endpackage
